// ### common/csb_cfg.svh
// Constants for the chop sequencer and bias control block
`ifndef CSB_CFG_SVH
`define CSB_CFG_SVH
`define CSB_OFS_GAIN_DELAY 8'h03
`define CSB_OFS_RATE 8'h04
`define CSB_OFS_EXC_MAG 8'h06
`define CSB_OFS_EXC_ROUTE 8'h07
`define CSB_OFS_BIAS 8'h08
`define CSB_OFS_SYSCTL 8'h09
`define CSB_RST_GAIN_DELAY 8'h00
`define CSB_RST_RATE 8'h14
`define CSB_RST_EXC_MAG 8'h00
`define CSB_RST_EXC_ROUTE 8'hFF
`define CSB_RST_BIAS 8'h00
`define CSB_RST_SYSCTL 8'h10
`define CSB_CHOP_BIT 7
`define CSB_SINC3_BIT 4
`define CSB_DELAY_LSB 5
`define CSB_BIAS_LEVEL_BIT 7
`define CSB_CLK_PER_MOD 16
`define CSB_DELAY_MODS 28
`define CSB_START_FALL_EDGE 7
`define CSB_CLK_NS 10
`define CSB_FCLK_NS 244
`endif

// ### common/csb_pkg.sv
// Types for the chop sequencer and bias control block
package csb_pkg;
	typedef enum logic [1:0] {
		CSB_IDLE = 2'b00,
		CSB_SETTLE = 2'b01,
		CSB_CONV = 2'b10
	} csb_state_e;
	typedef struct packed {
		logic [3:0] excitation_magnitude;
		logic [3:0] source1_route;
		logic [3:0] source2_route;
		logic bias_level_sel;
		logic [6:0] bias_pin_connect;
		logic [2:0] monitor_select;
	} csb_analog_s;
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
	} csb_wr_s;
endpackage : csb_pkg

// ### test/csb_host_model.sv
// Host-side model: trigger pin, start-command frames and converter results
`timescale 1ns/1ns
`default_nettype none
module csb_host_model #(
	parameter int SETTLE_CLKS = 28
) (
	input wire logic clk,
	input wire logic input_swap,
	output logic start_pin,
	output logic sclk,
	output logic start_cmd,
	output logic [23:0] raw_result
);
	// Reference enable lives outside this block; delay field stays at default
	localparam logic [2:0] DELAY_CODE = 3'h0;
	initial begin
		start_pin = 1'b0;
		sclk = 1'b0;
		start_cmd = 1'b0;
	end
	// Polarity-dependent result, so a true average differs from both inputs
	assign raw_result = input_swap ? 24'h000100 : 24'h000300;
	// Bias settling is waited out before each pin trigger, not command triggers, scaled for simulation
	task automatic settle();
		repeat (SETTLE_CLKS) @(negedge clk);
	endtask : settle
	task automatic pulse_start();
		settle();
		start_pin = 1'b1;
		repeat (4) @(negedge clk);
		start_pin = 1'b0;
	endtask : pulse_start
	// Serial clock only moves inside a frame
	task automatic cmd_edges(input int n);
		start_cmd = 1'b1;
		repeat (n) begin
			repeat (4) @(negedge clk);
			sclk = 1'b1;
			repeat (4) @(negedge clk);
			sclk = 1'b0;
		end
	endtask : cmd_edges
	task automatic cmd_end();
		repeat (4) @(negedge clk);
		start_cmd = 1'b0;
	endtask : cmd_end
endmodule : csb_host_model
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the chop sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_top import csb_pkg::*;;
	localparam int MODS = 4;
	localparam int CONV = (28 + MODS) * 384;
	logic clk, rst_n, wr_en, start_pin, sclk, start_cmd;
	logic result_valid, input_swap, converting, s;
	logic [7:0] wr_addr, wr_data, rd_data;
	logic [23:0] raw_result, chop_result;
	csb_analog_s analog_cfg;
	logic [7:0] ofs [6] = '{8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09};
	logic [7:0] rstv [6] = '{8'h00, 8'h14, 8'h00, 8'hFF, 8'h00, 8'h10};
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	csb_chop_seq #(.MOD_PERIODS(MODS)) dut (.clk(clk), .rst_n(rst_n), .start_pin(start_pin),
		.sclk(sclk), .start_cmd(start_cmd), .wr_en(wr_en), .wr_addr(wr_addr),
		.wr_data(wr_data), .raw_result(raw_result), .rd_data(rd_data),
		.chop_result(chop_result), .result_valid(result_valid), .input_swap(input_swap),
		.converting(converting), .analog_cfg(analog_cfg));
	csb_host_model host (.clk(clk), .input_swap(input_swap), .start_pin(start_pin),
		.sclk(sclk), .start_cmd(start_cmd), .raw_result(raw_result));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic stop_test();
		if (num_errors == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : stop_test
	// Ceiling well above the roughly 80k cycles the sequence needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 100000) begin
			num_errors++;
			stop_test();
		end
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		wr_en = 1'b1;
		wr_addr = a;
		wr_data = d;
		@(negedge clk);
		wr_en = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		wr_addr = a;
		@(negedge clk);
		check("rd_data", {24'h0, e}, {24'h0, rd_data});
	endtask : rd
	// Windows absorb the start latency of the pin and command paths
	task automatic wait_result(input int lo, input int hi);
		int n;
		n = 1;
		@(negedge clk);
		while (result_valid !== 1'b1 && n <= hi) begin
			@(negedge clk);
			n++;
		end
		check_count++;
		if (n < lo || n > hi) begin
			num_errors++;
			$display("[FAIL] result delay expected %0d..%0d seen %0d", lo, hi, n);
		end
		@(negedge clk);
		check("result_valid", 32'h0, {31'h0, result_valid});
	endtask : wait_result
	initial begin
		rst_n = 1'b0;
		wr_en = 1'b0;
		wr_addr = 8'h00;
		wr_data = 8'h00;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		for (int i = 0; i < 6; i++) rd(ofs[i], rstv[i]);
		check("analog_cfg", 32'({4'h0, 4'hF, 4'hF, 1'b0, 7'h00, 3'h0}), 32'(analog_cfg));
		wr(8'h05, 8'h55);
		rd(8'h05, 8'h00);
		wr(8'h06, 8'h0A);
		wr(8'h07, 8'h3C);
		wr(8'h08, 8'hC5);
		wr(8'h09, 8'h05);
		check("analog_cfg", 32'({4'hA, 4'hC, 4'h3, 1'b1, 7'h45, 3'h5}),
			32'(analog_cfg));
		rd(8'h08, 8'hC5);
		wr(8'h07, 8'h44);
		check("routes", 32'h44,
			{24'h0, analog_cfg.source2_route, analog_cfg.source1_route});
		for (int m = 0; m < 8; m++) begin
			wr(8'h09, 8'(m));
			check("monitor_select", 32'(m), {29'h0, analog_cfg.monitor_select});
		end
		host.cmd_edges(6);
		repeat (8) @(negedge clk);
		check("converting", 32'h0, {31'h0, converting});
		host.cmd_edges(1);
		repeat (8) @(negedge clk);
		check("converting", 32'h1, {31'h0, converting});
		host.cmd_edges(1);
		host.cmd_end();
		wait_result(CONV - 420, CONV + 400);
		check("chop_result", 32'h300, {8'h0, chop_result});
		check("input_swap", 32'h0, {31'h0, input_swap});
		wr(8'h03, {host.DELAY_CODE, 5'h00});
		rd(8'h03, {host.DELAY_CODE, 5'h00});
		wr(8'h04, 8'h94);
		rd(8'h04, 8'h94);
		host.pulse_start();
		wait_result(2 * CONV - 420, 2 * CONV + 400);
		check("chop_result", 32'h200, {8'h0, chop_result});
		s = input_swap;
		wait_result(CONV - 2, CONV + 2);
		check("chop_result", 32'h200, {8'h0, chop_result});
		check("input_swap", {31'h0, ~s}, {31'h0, input_swap});
		repeat (CONV / 2) @(negedge clk);
		host.pulse_start();
		wait_result(2 * CONV - 420, 2 * CONV + 400);
		check("chop_result", 32'h200, {8'h0, chop_result});
		rst_n = 1'b0;
		@(negedge clk);
		check("converting", 32'h0, {31'h0, converting});
		stop_test();
	end
endmodule : tb_top
`default_nettype wire

// ### verilog/csb_chop_seq.sv
// Chop conversion sequencer with excitation, bias and monitor configuration
`timescale 1ns/1ns
`default_nettype none
`include "csb_cfg.svh"
module csb_chop_seq import csb_pkg::*; #(
	parameter int DATA_W = 24,
	parameter int PERIOD_W = 20,
	parameter int MOD_PERIODS = 52865
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start_pin,
	input wire logic sclk,
	input wire logic start_cmd,
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [DATA_W-1:0] raw_result,
	output logic [7:0] rd_data,
	output logic [DATA_W-1:0] chop_result,
	output logic result_valid,
	output logic input_swap,
	output logic converting,
	output var csb_analog_s analog_cfg
);
	localparam int DELAY_MOD = `CSB_DELAY_MODS;
	localparam int CLK_NS = `CSB_CLK_NS;
	localparam int FCLK_NS = `CSB_FCLK_NS;
	// Converter clock period in system cycles, rounded down, at least one
	localparam int FCLK_CYC = (FCLK_NS / CLK_NS) < 1 ? 1 : FCLK_NS / CLK_NS;
	localparam int MOD_CYC = `CSB_CLK_PER_MOD * FCLK_CYC;

	logic [1:0] rst_sync;
	logic rst_i;
	logic [1:0] pin_sync;
	logic pin_d;
	logic [1:0] sclk_sync;
	logic sclk_d;
	logic [1:0] cmd_sync;
	logic [7:0] gain_delay, rate, exc_mag, exc_route, bias, sysctl;
	logic [7:0] next_gain_delay, next_rate, next_exc_mag, next_exc_route, next_bias, next_sysctl;
	csb_state_e state, next_state;
	logic [9:0] sub_cnt, next_sub_cnt;
	logic [PERIOD_W-1:0] mod_cnt, next_mod_cnt;
	logic [2:0] edge_cnt, next_edge_cnt;
	logic polarity, next_polarity;
	logic have_first, next_have_first;
	logic [DATA_W-1:0] last_res, next_last_res;
	logic [DATA_W-1:0] next_chop_result;
	logic next_result_valid;
	logic [7:0] next_rd_data;
	logic trigger;
	logic mod_tick;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_i = rst_sync[1];

	// Settling delay in modulator periods: 28 by default, doubling per field step
	function automatic logic [PERIOD_W-1:0] delay_mods(input logic [2:0] code);
		delay_mods = (code == 3'h0) ? PERIOD_W'(DELAY_MOD) : PERIOD_W'(DELAY_MOD) << code;
	endfunction : delay_mods

	function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] g,
			input logic [7:0] r, input logic [7:0] m, input logic [7:0] x,
			input logic [7:0] b, input logic [7:0] s);
		if (a == `CSB_OFS_GAIN_DELAY) begin
			reg_read = g;
		end else if (a == `CSB_OFS_RATE) begin
			reg_read = r;
		end else if (a == `CSB_OFS_EXC_MAG) begin
			reg_read = m;
		end else if (a == `CSB_OFS_EXC_ROUTE) begin
			reg_read = x;
		end else if (a == `CSB_OFS_BIAS) begin
			reg_read = b;
		end else if (a == `CSB_OFS_SYSCTL) begin
			reg_read = s;
		end else begin
			reg_read = 8'h00;
		end
	endfunction : reg_read

	always_ff @(posedge clk or negedge rst_i) begin
		if (!rst_i) begin
			pin_sync <= 2'h0;
			pin_d <= 1'b0;
			sclk_sync <= 2'h0;
			sclk_d <= 1'b0;
			cmd_sync <= 2'h0;
		end else begin
			pin_sync <= {pin_sync[0], start_pin};
			pin_d <= pin_sync[1];
			sclk_sync <= {sclk_sync[0], sclk};
			sclk_d <= sclk_sync[1];
			cmd_sync <= {cmd_sync[0], start_cmd};
		end
	end

	// Edge counter runs only while a start command frame is held
	always_comb begin
		next_edge_cnt = edge_cnt;
		trigger = pin_sync[1] & ~pin_d;
		if (!cmd_sync[1]) begin
			next_edge_cnt = 3'h0;
		end else if (sclk_d & ~sclk_sync[1]) begin
			next_edge_cnt = edge_cnt + 3'h1;
			if (edge_cnt == 3'(`CSB_START_FALL_EDGE - 1)) begin
				trigger = 1'b1;
			end
		end
	end

	always_comb begin
		next_gain_delay = gain_delay;
		next_rate = rate;
		next_exc_mag = exc_mag;
		next_exc_route = exc_route;
		next_bias = bias;
		next_sysctl = sysctl;
		if (wr_en) begin
			if (wr_addr == `CSB_OFS_GAIN_DELAY) begin
				next_gain_delay = wr_data;
			end else if (wr_addr == `CSB_OFS_RATE) begin
				next_rate = wr_data;
			end else if (wr_addr == `CSB_OFS_EXC_MAG) begin
				next_exc_mag = wr_data;
			end else if (wr_addr == `CSB_OFS_EXC_ROUTE) begin
				next_exc_route = wr_data;
			end else if (wr_addr == `CSB_OFS_BIAS) begin
				next_bias = wr_data;
			end else if (wr_addr == `CSB_OFS_SYSCTL) begin
				next_sysctl = wr_data;
			end
		end
		next_rd_data = reg_read(wr_addr, gain_delay, rate, exc_mag, exc_route, bias, sysctl);
	end

	assign mod_tick = (sub_cnt == 10'(MOD_CYC - 1));

	// Each conversion = settling delay then the nominal period in modulator ticks.
	// Counting whole conversions keeps the filter's own notches untouched.
	always_comb begin
		next_state = state;
		next_sub_cnt = mod_tick ? 10'h0 : sub_cnt + 10'h1;
		next_mod_cnt = mod_cnt;
		next_polarity = polarity;
		next_have_first = have_first;
		next_last_res = last_res;
		next_chop_result = chop_result;
		next_result_valid = 1'b0;
		if (trigger) begin
			next_state = CSB_SETTLE;
			next_sub_cnt = 10'h0;
			next_mod_cnt = delay_mods(gain_delay[`CSB_DELAY_LSB +: 3]);
			next_polarity = 1'b0;
			next_have_first = 1'b0;
		end else begin
			case (state)
				CSB_IDLE: begin
					next_mod_cnt = '0;
				end
				CSB_SETTLE: begin
					if (mod_tick) begin
						if (mod_cnt <= PERIOD_W'(1)) begin
							next_state = CSB_CONV;
							next_mod_cnt = PERIOD_W'(MOD_PERIODS);
						end else begin
							next_mod_cnt = mod_cnt - PERIOD_W'(1);
						end
					end
				end
				CSB_CONV: begin
					if (mod_tick) begin
						if (mod_cnt <= PERIOD_W'(1)) begin
							next_last_res = raw_result;
							if (rate[`CSB_CHOP_BIT]) begin
								// Pipelined pairs give a result every conversion after the first
								next_polarity = ~polarity;
								next_have_first = 1'b1;
								if (have_first) begin
									next_chop_result = DATA_W'(({raw_result[DATA_W-1], raw_result}
										+ {last_res[DATA_W-1], last_res}) >>> 1);
									next_result_valid = 1'b1;
								end
								next_state = CSB_SETTLE;
								next_mod_cnt = delay_mods(gain_delay[`CSB_DELAY_LSB +: 3]);
							end else begin
								next_chop_result = raw_result;
								next_result_valid = 1'b1;
								next_state = CSB_SETTLE;
								next_mod_cnt = delay_mods(gain_delay[`CSB_DELAY_LSB +: 3]);
							end
						end else begin
							next_mod_cnt = mod_cnt - PERIOD_W'(1);
						end
					end
				end
				default: begin
					next_state = CSB_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_i) begin
		if (!rst_i) begin
			gain_delay <= `CSB_RST_GAIN_DELAY;
			rate <= `CSB_RST_RATE;
			exc_mag <= `CSB_RST_EXC_MAG;
			exc_route <= `CSB_RST_EXC_ROUTE;
			bias <= `CSB_RST_BIAS;
			sysctl <= `CSB_RST_SYSCTL;
			state <= CSB_IDLE;
			sub_cnt <= 10'h0;
			mod_cnt <= '0;
			edge_cnt <= 3'h0;
			polarity <= 1'b0;
			have_first <= 1'b0;
			last_res <= '0;
			chop_result <= '0;
			result_valid <= 1'b0;
			rd_data <= 8'h00;
			input_swap <= 1'b0;
			converting <= 1'b0;
			analog_cfg <= '0;
		end else begin
			gain_delay <= next_gain_delay;
			rate <= next_rate;
			exc_mag <= next_exc_mag;
			exc_route <= next_exc_route;
			bias <= next_bias;
			sysctl <= next_sysctl;
			state <= next_state;
			sub_cnt <= next_sub_cnt;
			mod_cnt <= next_mod_cnt;
			edge_cnt <= next_edge_cnt;
			polarity <= next_polarity;
			have_first <= next_have_first;
			last_res <= next_last_res;
			chop_result <= next_chop_result;
			result_valid <= next_result_valid;
			rd_data <= next_rd_data;
			input_swap <= next_polarity & next_rate[`CSB_CHOP_BIT];
			converting <= (next_state != CSB_IDLE);
			analog_cfg <= {next_exc_mag[3:0], next_exc_route[3:0],
				next_exc_route[7:4], next_bias[`CSB_BIAS_LEVEL_BIT],
				next_bias[6:0], next_sysctl[2:0]};
		end
	end

	// Conversion end not overridden by a trigger: the step the chop checks hang from
	sequence s_conv_done;
		state == CSB_CONV && mod_tick && mod_cnt <= PERIOD_W'(1) && !trigger;
	endsequence
	sequence s_chop_done;
		s_conv_done ##0 rate[`CSB_CHOP_BIT];
	endsequence

	a_trigger_restart: assert property (@(posedge clk) disable iff (!rst_i)
		trigger |=> state == CSB_SETTLE && !have_first)
		else $error("trigger did not restart sequence");
	a_pin_start: assert property (@(posedge clk) disable iff (!rst_i)
		pin_sync[1] && !pin_d |=> converting)
		else $error("pin rise did not start conversion");
	a_mod_tick_period: assert property (@(posedge clk) disable iff (!rst_i)
		mod_tick |=> !mod_tick [*8])
		else $error("modulator tick too frequent");
	a_delay_reload: assert property (@(posedge clk) disable iff (!rst_i)
		s_conv_done |=> mod_cnt == delay_mods($past(gain_delay[`CSB_DELAY_LSB +: 3])))
		else $error("settling delay not reinserted");
	a_swap_each: assert property (@(posedge clk) disable iff (!rst_i)
		s_chop_done |=> polarity != $past(polarity))
		else $error("polarity not reversed");
	a_average_out: assert property (@(posedge clk) disable iff (!rst_i)
		next_result_valid && rate[`CSB_CHOP_BIT]
		|=> chop_result == DATA_W'(({$past(raw_result[DATA_W-1]), $past(raw_result)}
			+ {$past(last_res[DATA_W-1]), $past(last_res)}) >>> 1))
		else $error("chop result not averaged");
	// Looks at the pair flag as it stood before the completing edge
	a_first_pair: assert property (@(posedge clk) disable iff (!rst_i)
		result_valid && $past(rate[`CSB_CHOP_BIT]) |-> $past(have_first))
		else $error("chop result before pair complete");
	a_cfg_mirror: assert property (@(posedge clk) disable iff (!rst_i)
		wr_en && wr_addr == `CSB_OFS_SYSCTL
		|=> analog_cfg.monitor_select == $past(wr_data[2:0]))
		else $error("monitor select not applied");
	a_bias_mirror: assert property (@(posedge clk) disable iff (!rst_i)
		wr_en && wr_addr == `CSB_OFS_BIAS
		|=> analog_cfg.bias_level_sel == $past(wr_data[`CSB_BIAS_LEVEL_BIT])
			&& analog_cfg.bias_pin_connect == $past(wr_data[6:0]))
		else $error("bias setting not applied");
endmodule : csb_chop_seq
`default_nettype wire
